// File: pkg/bst_map.svh
// Constants for the boundary scan test port: codes, sizes and presets.
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

// Instruction register width and instruction codes.
`define BST_IR_W        3
`define BST_OP_EXTEST   3'h0
`define BST_OP_IDCODE   3'h1
`define BST_OP_SAMPLEZ  3'h2
`define BST_OP_SAMPLE   3'h4
`define BST_OP_BYPASS   3'h7

// Pattern forced into the two low bits at instruction capture.
`define BST_IR_CAPTURE  3'h1

// Identification register width and presence bit position.
`define BST_ID_W        32
`define BST_ID_PRESENT  0

// Boundary register length and the output-drive cell position.
`define BST_BSR_LEN     96
`define BST_OE_CELL     89

// Output-drive cell preset: output bus enabled.
`define BST_OE_PRESET   1'b1

`endif

// File: pkg/bst_pkg.sv
// Types shared by the boundary scan test port.
`include "bst_map.svh"

package bst_pkg;

  // The sixteen states of the test state machine.
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } bst_state_e;

  // Test control handed from the test clock to the memory clock.
  typedef struct packed {
    logic                      extest;
    logic                      samplez;
    logic                      q_oe;
    logic [`BST_BSR_LEN-1:0]   pattern;
  } bst_ctrl_s;

endpackage : bst_pkg

// File: core/bst_tap.sv
// Boundary scan test access port of a synchronous burst memory.
// Function
// - Sample on rising, drive on falling edge.
// - Mode-select steers state machine each rising edge.
// - Shift in at MSB, out at LSB.
// - Serial output driven only while shifting.
// - Five high mode-select edges reset test logic.
// - Power-up resets test logic, output floats.
// - Exactly one register between data pins.
// - Three-bit instruction, preset to identification read.
// - Instruction capture loads 01 low bits.
// - Bypass flip-flop captures zero.
// - Boundary register captures pins, shifts serially.
// - Identification read captures fixed 32-bit code.
// - New instruction applies only at update.
// - Output-float sample floats bus, selects boundary.
// - Sample/preload snapshots pin values.
// - Latched outputs hold preload; shift concurrently.
// - Bypass instruction selects bypass flip-flop.
// - External test drives preloaded pattern out.
// - Output-drive cell gates bus under external test.
// - Output-drive cell preset high on reset.
// - Identification bit zero always reads one.
`timescale 1ns/10ps

`include "bst_map.svh"

module bst_tap #(
  parameter logic [`BST_ID_W-1:0] ID_CODE = 32'h1000_0001 // Arbitrary value.
) (
  // Memory-side clock and power-up reset.
  input  wire logic                     sys_clk_in,
  input  wire logic                     nrst_in,
  // Test port pins.
  input  wire logic                     tck_in,
  input  wire logic                     tms_in,
  input  wire logic                     tdi_in,
  output logic                          tdo_out,
  output logic                          tdo_oe_out,
  // Memory pin values seen by the boundary cells.
  input  wire logic [`BST_BSR_LEN-1:0]  pins_in,
  // Test control toward the memory pins, on the memory clock.
  output logic                          test_extest_out,
  output logic                          test_samplez_out,
  output logic                          test_q_oe_out,
  output logic [`BST_BSR_LEN-1:0]       test_pattern_out
);

  // Test clock domain state. All but the synchronisers is reset by the synchronised
  // power-up reset, and all of it runs only while the test clock toggles.
  logic                         rst_meta_r;
  logic                         rst_sync_r;
  logic                         tms_meta_r;
  logic                         tms_r;
  logic                         tdi_meta_r;
  logic                         tdi_r;
  logic [`BST_BSR_LEN-1:0]      pins_meta_r;
  logic [`BST_BSR_LEN-1:0]      pins_r;
  bst_pkg::bst_state_e          state_r;
  bst_pkg::bst_state_e          state_nxt;
  logic [`BST_IR_W-1:0]         ir_shift_r;
  logic [`BST_IR_W-1:0]         ir_r;
  logic                         bypass_r;
  logic [`BST_ID_W-1:0]         id_r;
  logic [`BST_BSR_LEN-1:0]      bsr_r;
  logic [`BST_BSR_LEN-1:0]      preload_r;
  logic                         tdo_r;
  logic                         tdo_oe_r;
  logic                         serial_bit;
  bst_pkg::bst_ctrl_s           ctrl_nxt;
  logic                         ctrl_tgl_r;
  logic                         upd_evt;

  // Memory clock domain state. Only the toggle crosses bit by bit; the
  // control word is copied whole once the toggle has settled.
  logic                         tgl_meta_r;
  logic                         tgl_sync_r;
  logic                         tgl_seen_r;
  bst_pkg::bst_ctrl_s           out_r;

  // Decides whether an instruction routes the boundary register.
  // Reserved codes fall through to the bypass path.
  function automatic logic uses_bsr(input logic [`BST_IR_W-1:0] op);
    uses_bsr = (op == `BST_OP_EXTEST) || (op == `BST_OP_SAMPLE) ||
               (op == `BST_OP_SAMPLEZ);
  endfunction : uses_bsr

  // True in the two shifting states, where the serial output is live.
  function automatic logic in_shift(input bst_pkg::bst_state_e st);
    in_shift = (st == bst_pkg::SH_DR) || (st == bst_pkg::SH_IR);
  endfunction : in_shift

  // Reset release is synchronised to the test clock; assertion is async.
  // Without this a release close to a test-clock edge could leave part
  // of the state machine in reset and part of it running.
  always_ff @(posedge tck_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // rising-edge input sampling
  // Test inputs and memory pins pass two flip-flops before use.
  // The pipe adds two test-clock edges of latency, which the controller
  // must allow for. Idle values match the pulled-up pin levels, so no
  // false mode-select low is seen straight after reset.
  always_ff @(posedge tck_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tms_meta_r  <= 1'b1;
      tms_r       <= 1'b1;
      tdi_meta_r  <= 1'b1;
      tdi_r       <= 1'b1;
      pins_meta_r <= '0;
      pins_r      <= '0;
    end else begin
      tms_meta_r  <= tms_in;
      tms_r       <= tms_meta_r;
      tdi_meta_r  <= tdi_in;
      tdi_r       <= tdi_meta_r;
      pins_meta_r <= pins_in;
      pins_r      <= pins_meta_r;
    end
  end

  // standard transition graph
  // Next state from the sampled mode-select value.
  // Five high values in a row reach reset from any state, whatever the
  // starting point, so the controller can always recover the port.
  always_comb begin
    case (state_r)
      bst_pkg::TLR:    state_nxt = tms_r ? bst_pkg::TLR    : bst_pkg::RTI;
      bst_pkg::RTI:    state_nxt = tms_r ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_DR: state_nxt = tms_r ? bst_pkg::SEL_IR : bst_pkg::CAP_DR;
      bst_pkg::CAP_DR: state_nxt = tms_r ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
      bst_pkg::SH_DR:  state_nxt = tms_r ? bst_pkg::EX1_DR : bst_pkg::SH_DR;
      bst_pkg::EX1_DR: state_nxt = tms_r ? bst_pkg::UPD_DR : bst_pkg::PAU_DR;
      bst_pkg::PAU_DR: state_nxt = tms_r ? bst_pkg::EX2_DR : bst_pkg::PAU_DR;
      bst_pkg::EX2_DR: state_nxt = tms_r ? bst_pkg::UPD_DR : bst_pkg::SH_DR;
      bst_pkg::UPD_DR: state_nxt = tms_r ? bst_pkg::SEL_DR : bst_pkg::RTI;
      bst_pkg::SEL_IR: state_nxt = tms_r ? bst_pkg::TLR    : bst_pkg::CAP_IR;
      bst_pkg::CAP_IR: state_nxt = tms_r ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
      bst_pkg::SH_IR:  state_nxt = tms_r ? bst_pkg::EX1_IR : bst_pkg::SH_IR;
      bst_pkg::EX1_IR: state_nxt = tms_r ? bst_pkg::UPD_IR : bst_pkg::PAU_IR;
      bst_pkg::PAU_IR: state_nxt = tms_r ? bst_pkg::EX2_IR : bst_pkg::PAU_IR;
      bst_pkg::EX2_IR: state_nxt = tms_r ? bst_pkg::UPD_IR : bst_pkg::SH_IR;
      bst_pkg::UPD_IR: state_nxt = tms_r ? bst_pkg::SEL_DR : bst_pkg::RTI;
      default:         state_nxt = bst_pkg::TLR;
    endcase
  end

  // power-up reset
  // Any state reaches reset after five high mode-select edges.
  // The memory side keeps running through this reset; only the instruction
  // fields and the output-drive cell bit of the test control word's pattern return to their idle values.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= bst_pkg::TLR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // capture 01 pattern
  // Instruction shift stage.
  // Capture keeps the top bit of the current instruction and forces the
  // fixed pattern below it, so a broken chain shows up on the board.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ir_shift_r <= `BST_OP_IDCODE;
    end else if (state_r == bst_pkg::CAP_IR) begin
      ir_shift_r <= {ir_r[`BST_IR_W-1:2], 2'(`BST_IR_CAPTURE)};
    end else if (state_r == bst_pkg::SH_IR) begin
      ir_shift_r <= {tdi_r, ir_shift_r[`BST_IR_W-1:1]};
    end
  end

  // apply at update only
  // Current instruction, replaced at instruction update and reset to identification read in test reset.
  // Bits shifting through the stage never reach the memory pins until
  // the controller passes the update state.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ir_r <= `BST_OP_IDCODE;
    end else if (state_r == bst_pkg::TLR) begin
      ir_r <= `BST_OP_IDCODE;
    end else if (state_r == bst_pkg::UPD_IR) begin
      ir_r <= ir_shift_r;
    end
  end

  // bypass path shift
  // Single-bit bypass stage; reserved codes also use it.
  // It captures zero, so a bypassed device adds one known bit to a chain.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      bypass_r <= 1'b0;
    end else if (state_r == bst_pkg::CAP_DR) begin
      bypass_r <= 1'b0;
    end else if (state_r == bst_pkg::SH_DR) begin
      bypass_r <= tdi_r;
    end
  end

  // presence bit forced
  // Identification register loads the fixed code and shifts it out.
  // The presence bit is forced here, whatever the parameter holds.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      id_r <= '0;
    end else if (ir_r == `BST_OP_IDCODE) begin
      if (state_r == bst_pkg::CAP_DR) begin
        id_r <= ID_CODE | (`BST_ID_W'(1) << `BST_ID_PRESENT);
      end else if (state_r == bst_pkg::SH_DR) begin
        id_r <= {tdi_r, id_r[`BST_ID_W-1:1]};
      end
    end
  end

  // sample snapshot
  // Boundary shift stage; the output-drive cell captures its own latch.
  // Pin values are only as good as the synchroniser allows: a pin that
  // moves near the capture edge may be seen either way.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      bsr_r <= '0;
    end else if (uses_bsr(ir_r)) begin
      if (state_r == bst_pkg::CAP_DR) begin
        bsr_r                <= pins_r;
        bsr_r[`BST_OE_CELL]  <= preload_r[`BST_OE_CELL];
      end else if (state_r == bst_pkg::SH_DR) begin
        bsr_r <= {tdi_r, bsr_r[`BST_BSR_LEN-1:1]};
      end
    end
  end

  // output-drive cell preset
  // Update latches hold the preloaded pattern while shifting goes on.
  // Only the output-drive cell returns to its preset in reset; the rest
  // of the pattern has no effect until external test is chosen.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      preload_r               <= '0;
      preload_r[`BST_OE_CELL] <= `BST_OE_PRESET;
    end else if (state_r == bst_pkg::TLR) begin
      preload_r[`BST_OE_CELL] <= `BST_OE_PRESET;
    end else if (state_r == bst_pkg::UPD_DR && uses_bsr(ir_r)) begin
      preload_r <= bsr_r;
    end
  end

  // one register selected
  // Serial source chosen from the state and current instruction.
  // Exactly one stage feeds the output at any time.
  always_comb begin
    if (state_r == bst_pkg::SH_IR) begin
      serial_bit = ir_shift_r[0];
    end else if (uses_bsr(ir_r)) begin
      serial_bit = bsr_r[0];
    end else if (ir_r == `BST_OP_IDCODE) begin
      serial_bit = id_r[0];
    end else begin
      serial_bit = bypass_r;
    end
  end

  // drive only while shifting
  // Serial output updates on the falling test-clock edge.
  // Half a period of settling lets the controller sample on the rise.
  always_ff @(negedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else begin
      tdo_r    <= serial_bit;
      tdo_oe_r <= in_shift(state_r);
    end
  end

  // Serial output pins.
  assign tdo_out    = tdo_r;
  assign tdo_oe_out = tdo_oe_r;

  // output-drive cell gate
  // Test control as seen by the memory's pins.
  // Built only from test-clock registers, so it is steady between the
  // edges on which the instruction or the update latches change.
  always_comb begin
    ctrl_nxt.extest  = (ir_r == `BST_OP_EXTEST);
    ctrl_nxt.samplez = (ir_r == `BST_OP_SAMPLEZ);
    ctrl_nxt.q_oe    = ctrl_nxt.samplez ? 1'b0 :
                       (ctrl_nxt.extest ? preload_r[`BST_OE_CELL] : 1'b1);
    ctrl_nxt.pattern = preload_r;
  end

  // Marks the edges on which the control word takes a new value.
  // The flag fires on the same edge as the change, so the last edge of
  // a frame is enough: the test clock may stop right after it.
  always_comb begin
    upd_evt = (state_r == bst_pkg::TLR) || (state_r == bst_pkg::UPD_IR) ||
              ((state_r == bst_pkg::UPD_DR) && uses_bsr(ir_r));
  end

  // Toggle flips with every update of the control word.
  // Updates are at least one test-clock period apart, longer than the
  // few memory clocks the copy below needs.
  always_ff @(posedge tck_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctrl_tgl_r <= 1'b0;
    end else if (upd_evt) begin
      ctrl_tgl_r <= ~ctrl_tgl_r;
    end
  end

  // Toggle synchroniser and change detector on the memory clock.
  // Only the toggle passes the two flip-flops; the word itself waits.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tgl_meta_r <= 1'b0;
      tgl_sync_r <= 1'b0;
      tgl_seen_r <= 1'b0;
    end else begin
      tgl_meta_r <= ctrl_tgl_r;
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  // Stable control word copied once the toggle has crossed.
  // By then the word has been steady for two memory clocks, so every bit
  // is taken from the same update.
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      out_r.extest  <= 1'b0;
      out_r.samplez <= 1'b0;
      out_r.q_oe    <= 1'b1;
      out_r.pattern <= '0;
    end else if (tgl_sync_r != tgl_seen_r) begin
      out_r <= ctrl_nxt;
    end
  end

  // Test control pins, straight from the memory-clock copy.
  assign test_extest_out  = out_r.extest;
  assign test_samplez_out = out_r.samplez;
  assign test_q_oe_out    = out_r.q_oe;
  assign test_pattern_out = out_r.pattern;

endmodule : bst_tap

// File: dv/bst_tap_properties.sv
// Pin-level checker for the boundary scan test port, with its bind.
`timescale 1ns/10ps
module bst_tap_chk (
  // Clocks and reset.
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic tck_in,
  // Test port pins.
  input wire logic tms_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  // Test control toward the memory pins.
  input wire logic test_extest_out,
  input wire logic test_samplez_out,
  input wire logic test_q_oe_out
);
  // Serial output and its enable move only while the test clock is low.
  property p_tdo_fall;
    @(posedge sys_clk_in) disable iff (!nrst_in) $changed(tdo_out) |-> !tck_in;
  endproperty
  a_tdo_fall: assert property (p_tdo_fall)
    else $error("tdo moved while tck high");
  property p_oe_fall;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      $changed(tdo_oe_out) |-> !tck_in;
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("tdo enable moved while tck high");
  // Leaving reset finds the output floating and the bus enabled.
  property p_pwr;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      $rose(nrst_in) |-> !tdo_oe_out && test_q_oe_out && !test_extest_out;
  endproperty
  a_pwr: assert property (p_pwr)
    else $error("bad state after reset");
  // Output bus enable follows the current instruction; at most one instruction is current.
  property p_z_float;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      test_samplez_out |-> !test_q_oe_out;
  endproperty
  a_z_float: assert property (p_z_float)
    else $error("bus driven under output float");
  property p_q_drive;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      !test_extest_out && !test_samplez_out |-> test_q_oe_out;
  endproperty
  a_q_drive: assert property (p_q_drive)
    else $error("bus floated outside external test");
  property p_one_op;
    @(posedge sys_clk_in) disable iff (!nrst_in)
      !(test_extest_out && test_samplez_out);
  endproperty
  a_one_op: assert property (p_one_op)
    else $error("two instructions current");
  // Five high mode-select edges, plus the input pipe, reach reset.
  property p_tlr_oe;
    @(posedge tck_in) disable iff (!nrst_in) tms_in [*5] |-> ##4 !tdo_oe_out;
  endproperty
  a_tlr_oe: assert property (p_tlr_oe)
    else $error("tdo driven after mode-select reset");
  property p_tlr_ctl;
    @(posedge tck_in) disable iff (!nrst_in) tms_in [*5] |->
      ##4 test_q_oe_out && !test_extest_out && !test_samplez_out;
  endproperty
  a_tlr_ctl: assert property (p_tlr_ctl)
    else $error("test control kept after reset");
  // Main scenarios reached.
  c_extest: cover property (@(posedge sys_clk_in) $rose(test_extest_out));
  c_samplez: cover property (@(posedge sys_clk_in) $rose(test_samplez_out));
  c_shift: cover property (@(posedge tck_in) $rose(tdo_oe_out));
endmodule : bst_tap_chk

bind bst_tap bst_tap_chk chk_u (
  .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .tck_in(tck_in),
  .tms_in(tms_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out),
  .test_extest_out(test_extest_out), .test_samplez_out(test_samplez_out),
  .test_q_oe_out(test_q_oe_out));

// File: dv/bst_ctl_model.sv
// Model of the external test controller that drives the test port.
`timescale 1ns/10ps
module bst_ctl_model (
  // Test port pins toward the device.
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out,
  // Serial output from the device.
  input  wire logic tdo_in,
  input  wire logic tdo_oe_in
);
  // Clock stands still low; pulled-up lines rest high between frames.
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end

  // Steers states, bits change after falling edges.
  // Callers hand over only defined instruction codes.
  task automatic scan(input logic [127:0] ms, di, input int n,
                      output logic [127:0] dout);
    logic [129:0] rec;
    #1.3;
    for (int i = 0; i < n + 2; i++) begin
      tms_out = (i < n) ? ms[i] : 1'b0;
      tdi_out = (i < n) ? di[i] : ~tdi_out;
      #16 tck_out = 1'b1;
      rec[i] = tdo_oe_in ? tdo_in : 1'bx; // Floating output reads unknown.
      #16 tck_out = 1'b0;
    end
    tms_out = 1'b1;
    tdi_out = 1'b1;
    dout = rec[129:2];
  endtask : scan
endmodule : bst_ctl_model

// File: dv/tb_top.sv
// Self-checking bench for the boundary scan test port.
`timescale 1ns/10ps
`include "bst_map.svh"
module tb_top;
  // Expected result notes, oldest first.
  typedef struct {
    string        nm;
    logic [127:0] v;
  } bst_note_s;
  localparam logic [31:0] ID_SET = 32'h2468_ace0; // Arbitrary value.
  logic         sys_clk_in = 1'b0;
  logic         nrst_in    = 1'b0;
  logic [95:0]  pins       = 96'h0;
  logic         tck, tms, tdi, tdo, tdo_oe, q_oe, extest, samplez;
  logic [95:0]  patt, pa, pb;
  logic [127:0] got, dout;
  bst_note_s    q[$];
  bst_note_s    nt;
  int           n_fail = 0;
  int           checks = 0;
  event         done;

  always #2 sys_clk_in = ~sys_clk_in;

  bst_tap #(.ID_CODE(ID_SET)) dut_u (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .pins_in(pins),
    .test_extest_out(extest), .test_samplez_out(samplez),
    .test_q_oe_out(q_oe), .test_pattern_out(patt));
  bst_ctl_model ctl_u (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
    .tdo_in(tdo), .tdo_oe_in(tdo_oe));

  // Compares a seen value with an expected one and counts both.
  task automatic chk(input string nm, input logic [127:0] g, e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Takes the oldest note whenever a result appears.
  always @(done) begin
    nt = q.pop_front();
    chk(nt.nm, got, nt.v);
  end

  // Notes an expected value, masked to its width.
  task automatic note(input string nm, input logic [127:0] v, input int w);
    q.push_back('{nm, v & ((128'h1 << w) - 1)});
  endtask : note

  // Hands a seen value to the comparing process.
  task automatic look(input logic [127:0] g);
    got = g;
    -> done;
    #1;
  endtask : look

  // Notes and looks at a level output at once.
  task automatic see(input string nm, input logic [127:0] e, g);
    note(nm, e, 128);
    look(g);
  endtask : see

  // Starts a frame off the memory clock's edges.
  task automatic go(input logic [127:0] ms, di, input int n);
    @(negedge sys_clk_in);
    ctl_u.scan(ms, di, n, dout);
  endtask : go

  // Scans one register from idle: pre is 3 for data, 4 for instruction.
  task automatic scn(input int pre, input logic [127:0] di, input int w);
    go(((pre == 4) ? 128'h3 : 128'h1) | (128'h3 << (pre + w - 1)),
       di << pre, pre + w + 2);
    look((dout >> pre) & ((128'h1 << w) - 1));
  endtask : scn

  // Random pin or pattern word.
  function automatic logic [95:0] rnd();
    return {$urandom(), $urandom(), $urandom()};
  endfunction : rnd

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize

  // Cuts a hang short.
  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  // Main sequence: reset, then a data scan under each instruction but output-float sample.
  initial begin
    void'($urandom(32'hef6f));
    fork
      go(128'h1, 128'h1, 1);
      begin
        repeat (10) @(posedge sys_clk_in);
        see("oe_rst", 1'b0, tdo_oe);
        see("q_rst", 1'b1, q_oe);
        repeat (2) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
      end
    join
    go(128'h1f, '1, 6);
    note("idcode", ID_SET | 32'h1, 32);
    scn(3, rnd(), 32);
    note("ir_cap", 3'h1, 3);
    scn(4, `BST_OP_BYPASS, 3);
    pa = rnd();
    note("bypass", {pa[6:0], 1'b0}, 8);
    scn(3, pa, 8);
    note("ir_cap", 3'h5, 3);
    scn(4, `BST_OP_SAMPLE, 3);
    pb = rnd();
    @(posedge sys_clk_in) pins <= pb;
    pb[`BST_OE_CELL] = `BST_OE_PRESET;
    pa[`BST_OE_CELL] = 1'b0;
    note("sample", pb, 96);
    scn(3, pa, 96);
    see("preload", pa, patt);
    note("ir_cap", 3'h5, 3);
    scn(4, `BST_OP_EXTEST, 3);
    see("extest", 1'b1, extest);
    see("q_float", 1'b0, q_oe);
    see("drive", pa, patt);
    pb[`BST_OE_CELL] = 1'b0;
    pa[`BST_OE_CELL] = 1'b1;
    note("ext_cap", pb, 96);
    scn(3, pa, 96);
    see("q_drive", 1'b1, q_oe);
    note("ir_cap", 3'h1, 3);
    scn(4, `BST_OP_SAMPLEZ, 3);
    see("samplez", 1'b1, samplez);
    see("q_z", 1'b0, q_oe);
    see("ext_off", 1'b0, extest);
    go(128'h1f, '1, 6);
    see("z_off", 1'b0, samplez);
    see("q_tlr", 1'b1, q_oe);
    note("id_tlr", ID_SET | 32'h1, 32);
    scn(3, rnd(), 32);
    summarize();
  end
endmodule : tb_top
